/* File: rtl/cfg_flash_pkg.sv */
// Constants and helpers for the burst-read configuration flash
package cfg_flash_pkg;

  // ------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int WORDS = 8388608;
  localparam int MAIN_BLK_BITS = 16;
  localparam int PARAM_BLK_BITS = 14;
  localparam int BANK_BITS = 19;
  localparam logic [6:0] PARAM_REGION = 7'h7f;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ------------------------------------------------------------
  // Command codes on the low data byte
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;

  // ------------------------------------------------------------
  // Timing and pin synchroniser layout
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int POWERUP_NS = 1000;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_W = 46;
  localparam logic [SYNC_W-1:0] SYNC_RST = 46'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0;
  localparam logic [7:0] PU_RST = 8'h0;

  typedef enum logic [2:0] {ST_POWERUP, ST_READY, ST_PROG, ST_ERASE_CONF, ST_ERASING} flash_state_t;

  // First word of the erase block holding an address
  function automatic logic [ADDR_W-1:0] blk_base(input logic [ADDR_W-1:0] a);
    if (a[22:16] == PARAM_REGION) begin
      return {a[22:PARAM_BLK_BITS], 14'h0};
    end
    return {a[22:MAIN_BLK_BITS], 16'h0};
  endfunction

  // Last word of the erase block holding an address
  function automatic logic [ADDR_W-1:0] blk_last(input logic [ADDR_W-1:0] a);
    if (a[22:16] == PARAM_REGION) begin
      return {a[22:PARAM_BLK_BITS], 14'h3fff};
    end
    return {a[22:MAIN_BLK_BITS], 16'hffff};
  endfunction

endpackage

/* File: rtl/sync_burst_config_flash_read.sv */
// Configuration flash with power-on synchronous burst read, word program and block erase
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Deliver 16-bit words paced by config clock, no wait states inserted.
// - Drive ready/wait low while busy, release it once ready.
// - After ready, burst begins on next clock edges with no command.
// - Enter synchronous read mode at power-on without any command.
// - Stream words from latched start address via auto-incrementing counter.
// - One new 16-bit word on the data bus per config clock.
// - Latch burst start address from address inputs at sequence start.
// - Decode 23-bit word address over the full 8M-word array.
// - 131 erasable blocks grouped in sixteen 8 Mb banks.
// - Top 64K region split into four 16K parameter blocks.
// - Erase whole blocks only, program single words.
// - Pins: 23 address, 16 data, controls, bidirectional ready/wait.
module sync_burst_config_flash_read (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Address and control pins
  input wire logic [cfg_flash_pkg::ADDR_W-1:0] addr_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  input wire logic device_reset_n_i,
  input wire logic write_prot_n_i,
  input wire logic config_clk_i,
  input wire logic addr_latch_n_i,
  // Data pins
  input wire logic [cfg_flash_pkg::DATA_W-1:0] dq_i,
  output logic [cfg_flash_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  // Ready/wait pin, open drain
  input wire logic ready_wait_i,
  output logic ready_wait_o,
  output logic ready_wait_oe_o
);
  import cfg_flash_pkg::*;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic clk_prev_reg;
  logic we_prev_reg;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_dq;
  logic s_ce_n, s_oe_n, s_we_n, s_rst_n, s_wp_n, s_clk, s_lat_n;
  logic clk_rise, we_rise, burst_mode;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {addr_i, chip_sel_n_i, out_en_n_i, write_en_n_i, device_reset_n_i, write_prot_n_i,
                    config_clk_i, addr_latch_n_i, dq_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign {s_addr, s_ce_n, s_oe_n, s_we_n, s_rst_n, s_wp_n, s_clk, s_lat_n, s_dq} = sync2_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_prev_reg <= 1'b0;
      we_prev_reg <= 1'b1;
    end else begin
      clk_prev_reg <= s_clk;
      we_prev_reg <= s_we_n;
    end
  end

  assign clk_rise = s_clk && !clk_prev_reg;
  assign we_rise = s_we_n && !we_prev_reg && !s_ce_n;

  // ------------------------------------------------------------
  // Control state machine
  // ------------------------------------------------------------
  flash_state_t state_reg;
  logic [7:0] pu_cnt_reg;
  logic [ADDR_W-1:0] erase_ptr_reg;
  logic [ADDR_W-1:0] erase_last_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_POWERUP;
      pu_cnt_reg <= PU_RST;
      erase_ptr_reg <= ADDR_RST;
      erase_last_reg <= ADDR_RST;
    end else if (!s_rst_n) begin
      state_reg <= ST_POWERUP;
      pu_cnt_reg <= PU_RST;
    end else begin
      case (state_reg)
        ST_POWERUP: begin
          if (pu_cnt_reg == 8'(POWERUP_CYC - 1)) begin
            state_reg <= ST_READY;
          end else begin
            pu_cnt_reg <= pu_cnt_reg + 8'h1;
          end
        end
        ST_READY: begin
          if (we_rise && s_dq[7:0] == CMD_PROGRAM) begin
            state_reg <= ST_PROG;
          end else if (we_rise && s_dq[7:0] == CMD_ERASE) begin
            state_reg <= ST_ERASE_CONF;
          end
        end
        ST_PROG: begin
          if (we_rise) begin
            state_reg <= ST_READY;
          end
        end
        ST_ERASE_CONF: begin
          if (we_rise && s_dq[7:0] == CMD_CONFIRM && s_wp_n) begin
            state_reg <= ST_ERASING;
            erase_ptr_reg <= blk_base(s_addr);
            erase_last_reg <= blk_last(s_addr);
          end else if (we_rise) begin
            state_reg <= ST_READY;
          end
        end
        ST_ERASING: begin
          if (erase_ptr_reg == erase_last_reg) begin
            state_reg <= ST_READY;
          end else begin
            erase_ptr_reg <= erase_ptr_reg + 23'h1;
          end
        end
        default: state_reg <= ST_POWERUP;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Array storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:WORDS-1];
  logic mem_we;

  assign mem_we = (state_reg == ST_PROG && we_rise && s_wp_n) || state_reg == ST_ERASING;

  always_ff @(posedge clk_sys_i) begin
    if (state_reg == ST_ERASING) begin
      mem[erase_ptr_reg] <= ERASED_WORD;
    end else if (mem_we) begin
      mem[s_addr] <= s_dq;
    end
  end

  // ------------------------------------------------------------
  // Burst read path
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] burst_cnt_reg;

  assign burst_mode = state_reg == ST_READY && !s_ce_n && !s_oe_n && s_we_n;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      burst_cnt_reg <= ADDR_RST;
      dq_o <= DATA_RST;
    end else if (clk_rise && !s_ce_n && !s_lat_n) begin
      burst_cnt_reg <= s_addr;
    end else if (clk_rise && burst_mode) begin
      dq_o <= mem[burst_cnt_reg];
      burst_cnt_reg <= burst_cnt_reg + 23'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_oe_o <= 1'b0;
      ready_wait_o <= 1'b0;
      ready_wait_oe_o <= 1'b1;
    end else begin
      dq_oe_o <= burst_mode;
      ready_wait_o <= 1'b0;
      ready_wait_oe_o <= !(state_reg == ST_READY || state_reg == ST_PROG || state_reg == ST_ERASE_CONF);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_latch;
    clk_rise && !s_ce_n && !s_lat_n;
  endsequence

  sequence s_step;
    clk_rise && burst_mode && s_lat_n;
  endsequence

  a_latch_start_addr: assert property (s_latch |=> burst_cnt_reg == $past(s_addr))
    else $error("Burst start address not latched");
  a_burst_count_step: assert property (s_step |=> burst_cnt_reg == $past(burst_cnt_reg) + 23'h1)
    else $error("Burst counter did not advance by one");
  a_burst_wrap_zero: assert property (s_step ##0 (burst_cnt_reg == 23'h7fffff) |=> burst_cnt_reg == 23'h0)
    else $error("Burst counter did not wrap to zero");
  a_idle_counter_hold: assert property (!clk_rise |=> $stable(burst_cnt_reg))
    else $error("Burst counter moved without a clock edge");
  a_powerup_ready_time: assert property ($rose(s_rst_n) |-> ##[1:30] state_reg == ST_READY)
    else $error("Ready not reached after power-up delay");
  a_ready_wait_release: assert property (state_reg == ST_READY |=> !ready_wait_oe_o)
    else $error("Ready/wait still held low while ready");
  a_busy_holds_low: assert property (state_reg == ST_ERASING |=> ready_wait_oe_o ##0 !dq_oe_o)
    else $error("Ready/wait released during erase");
  a_erase_in_block: assert property (state_reg == ST_ERASING |-> erase_ptr_reg <= erase_last_reg
                                     && erase_last_reg - erase_ptr_reg <= 23'hffff)
    else $error("Erase pointer outside its block");
  a_protect_no_prog: assert property (state_reg == ST_PROG && !s_wp_n |-> !mem_we)
    else $error("Program accepted while write protected");
  a_drive_in_burst: assert property (burst_mode |=> dq_oe_o)
    else $error("Data bus not driven in burst");
  a_release_out_idle: assert property (!burst_mode |=> !dq_oe_o)
    else $error("Data bus driven outside burst");

endmodule

`default_nettype wire

/* File: testbench/cfg_port_model.sv */
// Model of the configuring device's parallel slave port
`timescale 1ns/1ps
`default_nettype none
module cfg_port_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Link side
  input wire logic config_clk_i,
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic ready_i,
  // Captured word
  output logic [15:0] word_o
);
  localparam logic [2:0] MODE_SEL = 3'b110;
  logic seen_reg;
  logic [7:0] dly_reg;
  // Find link clock rises
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_reg <= 1'b0;
      dly_reg <= 8'h0;
    end else begin
      seen_reg <= config_clk_i;
      dly_reg <= {dly_reg[6:0], config_clk_i & ~seen_reg};
    end
  end
  // Take a word late in each link cycle; a floating bus reads inverted
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_o <= 16'h0;
    end else if (dly_reg[5]) begin
      word_o <= (dq_oe_i && ready_i && MODE_SEL == 3'b110) ? dq_i : ~word_o;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_sync_burst_config_flash_read.sv */
// Testbench for the burst-read configuration flash
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_sync_burst_config_flash_read;
  import cfg_flash_pkg::*;
  typedef struct {logic [22:0] a; logic [15:0] d;} row_t;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [22:0] addr_i = 23'h0;
  logic chip_sel_n_i = 1'b1;
  logic out_en_n_i = 1'b1;
  logic write_en_n_i = 1'b1;
  logic device_reset_n_i = 1'b1;
  logic write_prot_n_i = 1'b1;
  logic config_clk_i = 1'b0;
  logic addr_latch_n_i = 1'b1;
  logic [15:0] dq_i = 16'h0;
  logic [15:0] dq_o;
  logic dq_oe_o;
  logic ready_wait_o;
  logic ready_wait_oe_o;
  logic [15:0] cap_word;
  wire rw_pin = ready_wait_oe_o ? ready_wait_o : 1'b1;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  row_t rows [4] = '{'{23'h0, 16'h1234}, '{23'h1, 16'habcd}, '{23'h2, 16'h0f0f}, '{23'h7fffff, 16'h5a5a}};
  sync_burst_config_flash_read u_sync_burst_config_flash_read (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .chip_sel_n_i(chip_sel_n_i), .out_en_n_i(out_en_n_i), .write_en_n_i(write_en_n_i),
    .device_reset_n_i(device_reset_n_i), .write_prot_n_i(write_prot_n_i), .config_clk_i(config_clk_i),
    .addr_latch_n_i(addr_latch_n_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .ready_wait_i(rw_pin),
    .ready_wait_o(ready_wait_o), .ready_wait_oe_o(ready_wait_oe_o));
  cfg_port_model u_cfg_port_model (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .config_clk_i(config_clk_i),
    .dq_i(dq_o), .dq_oe_i(dq_oe_o), .ready_i(rw_pin), .word_o(cap_word));
  // ------------------------------------------------------------
  // Clock and timeout
  // ------------------------------------------------------------
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    addr_i <= a;
    dq_i <= d;
    chip_sel_n_i <= 1'b0;
    write_en_n_i <= 1'b0;
    cyc(4);
    write_en_n_i <= 1'b1;
    cyc(4);
    chip_sel_n_i <= 1'b1;
    cyc(2);
  endtask
  // External link clock, 320 ns, still between frames
  task automatic tick();
    config_clk_i <= 1'b1;
    cyc(4);
    config_clk_i <= 1'b0;
    cyc(4);
  endtask
  task automatic start(input logic [22:0] a);
    addr_i <= a;
    addr_latch_n_i <= 1'b0;
    chip_sel_n_i <= 1'b0;
    out_en_n_i <= 1'b0;
    cyc(4);
    tick();
    addr_latch_n_i <= 1'b1;
    cyc(1);
  endtask
  task automatic burst(input logic [15:0] e);
    tick();
    `CHK("burst word", e, cap_word)
  endtask
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (rw_pin !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(4);
    arst_n_i <= 1'b1;
    cyc(2);
    `CHK("busy after reset", 1'b0, rw_pin)
    cyc(18);
    `CHK("busy in powerup", 1'b0, rw_pin)
    wait_ready(40);
    `CHK("ready", 1'b1, rw_pin)
    foreach (rows[i]) begin
      wr(rows[i].a, 16'h0040);
      wr(rows[i].a, rows[i].d);
    end
    start(ADDR_RST);
    for (int i = 0; i < 3; i++) begin
      burst(rows[i].d);
    end
    `CHK("dq driven", 1'b1, dq_oe_o)
    out_en_n_i <= 1'b1;
    cyc(6);
    `CHK("dq released", 1'b0, dq_oe_o)
    start(23'h7fffff);
    burst(rows[3].d);
    burst(rows[0].d);
    out_en_n_i <= 1'b1;
    chip_sel_n_i <= 1'b1;
    write_prot_n_i <= 1'b0;
    wr(23'h1, 16'h0040);
    wr(23'h1, 16'h0bad);
    write_prot_n_i <= 1'b1;
    wr(23'h0, 16'h0020);
    wr(23'h0, 16'h00ff);
    cyc(3);
    `CHK("erase refused", 1'b1, rw_pin)
    wr(23'h7fc000, 16'h0020);
    wr(23'h7fc000, 16'h00d0);
    cyc(3);
    `CHK("busy in erase", 1'b0, rw_pin)
    wait_ready(20000);
    `CHK("erase done", 1'b1, rw_pin)
    start(23'h7fffff);
    burst(ERASED_WORD);
    burst(rows[0].d);
    burst(rows[1].d);
    out_en_n_i <= 1'b1;
    chip_sel_n_i <= 1'b1;
    device_reset_n_i <= 1'b0;
    cyc(6);
    `CHK("busy in device reset", 1'b0, rw_pin)
    device_reset_n_i <= 1'b1;
    wait_ready(40);
    `CHK("ready again", 1'b1, rw_pin)
    arst_n_i <= 1'b0;
    cyc(2);
    `CHK("dq off in reset", 1'b0, dq_oe_o)
    `CHK("busy in reset", 1'b0, rw_pin)
    arst_n_i <= 1'b1;
    wait_ready(40);
    `CHK("ready after reset", 1'b1, rw_pin)
    stop_test();
  end
endmodule
`default_nettype wire
